// [rtl/sebs_bus_if.sv]
// Two-wire bus between master end and EEPROM slave end.
// Both SDA drivers are open drain; the pull-up is resolved here.
interface sebs_bus_if;
   logic scl;
   logic mst_sda_o;
   logic mst_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic sda;

   // Wired-AND with pull-up
   assign sda = ~((~mst_sda_oe_n & ~mst_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));

   modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
   modport mst (output scl, output mst_sda_o, output mst_sda_oe_n, input sda);
endinterface

// [rtl/sebs_dev.sv]
// EEPROM slave end of the two-wire bus: framing, addressing, acknowledge, write lockout.
// Assumes a byte store on the user side answering mem_rdata for mem_addr_q in the same cycle.
//
// Contract
// - Program cycle ends within 10 or 15 ms
// - Busy: bus ignored, SDA released, no ack
// - Reject SCL/SDA pulses below noise limit
// - Start opens, stop closes, receiver acknowledges
// - Type code 1010 must match after start
// - Chip bits compared with three address straps
// - Page is 16 bytes, block 256 bytes
// - System keeps bus total within 16384 bits
// - Master sends type, chip, block, byte address
// - SDA only pulled low or released
// - Master starts transfers and makes SCL
// - SDA changes only while SCL low
// - Start is SDA fall with SCL high
// - Stop is SDA rise, returns to standby
// - Transmitter releases; receiver acks ninth clock
// - Ack address and every written byte
// - Read: continue on ack, else await stop
// - Last address bit one reads, zero writes
// - Write takes eight-bit byte address next
module sebs_dev
   import sebs_pkg::*;
#(
   parameter bit FAST_MODE   = 1'b0,
   parameter bit LOW_VOLTAGE = 1'b0,
   parameter int PROG_CYCLES = LOW_VOLTAGE ? PROG_CYC_LV : PROG_CYC_STD
) (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   // Bus side
   sebs_bus_if.dev                bus,
   // Address straps
   input  wire logic              chip_select_strap_bit0,
   input  wire logic              chip_select_strap_bit1,
   input  wire logic              chip_select_strap_bit2,
   // Byte store
   output logic [ADDR_W-1:0]      mem_addr_q,
   output logic [7:0]             mem_wdata_q,
   output logic                   mem_we_q,
   input  wire logic [7:0]        mem_rdata,
   // Status
   output logic                   internal_program_time_q
);

   localparam int         FILT_CYC = FAST_MODE ? NOISE_FAST_CYC : NOISE_STD_CYC;
   localparam logic [2:0] FILT_END = 3'(FILT_CYC - 1);

   // ==========================================================
   // Input synchronisers and noise filter
   logic [1:0] line_s1_q;
   logic [1:0] line_s2_q;
   logic [1:0] line_f_q;
   logic [1:0] line_p_q;
   logic [2:0] strap_s1_q;
   logic [2:0] strap_s2_q;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         line_s1_q  <= 2'h3;
         line_s2_q  <= 2'h3;
         strap_s1_q <= 3'h0;
         strap_s2_q <= 3'h0;
      end else begin
         line_s1_q  <= {bus.sda, bus.scl};
         line_s2_q  <= line_s1_q;
         strap_s1_q <= {chip_select_strap_bit2, chip_select_strap_bit1, chip_select_strap_bit0};
         strap_s2_q <= strap_s1_q;
      end
   end

   // Index 0 is SCL, index 1 is SDA
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_filt
         logic [2:0] cnt_q;
         always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
               cnt_q          <= 3'h0;
               line_f_q[gi]   <= 1'b1;
            end else if (line_s2_q[gi] == line_f_q[gi]) begin
               cnt_q <= 3'h0;
            end else if (cnt_q == FILT_END) begin
               cnt_q        <= 3'h0;
               line_f_q[gi] <= line_s2_q[gi];
            end else begin
               cnt_q <= cnt_q + 3'h1;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         line_p_q <= 2'h3;
      end else begin
         line_p_q <= line_f_q;
      end
   end

   // ==========================================================
   // Bus events
   wire scl_f    = line_f_q[0];
   wire sda_f    = line_f_q[1];
   wire scl_rise = scl_f & ~line_p_q[0];
   wire scl_fall = ~scl_f & line_p_q[0];
   wire start_evt = scl_f & line_p_q[0] & line_p_q[1] & ~sda_f;
   wire stop_evt  = scl_f & line_p_q[0] & ~line_p_q[1] & sda_f;

   // ==========================================================
   // Frame state
   sebs_dev_state_t state_q;
   sebs_phase_t     phase_q;
   logic [3:0]      bit_q;
   logic [7:0]      rx_sh_q;
   logic [7:0]      tx_sh_q;
   logic            rd_sel_q;
   logic            m_ack_q;
   logic            wr_pend_q;
   logic            sda_rel_q;
   logic [31:0]     prog_cnt_q;

   wire type_ok  = rx_sh_q[7:TYPE_LO] == DEV_TYPE;
   wire chip_ok  = rx_sh_q[TYPE_LO-1:CHIP_LO] == strap_s2_q;
   wire addr_hit = type_ok & chip_ok;
   wire byte_in  = scl_fall & (bit_q == BIT_ACK);
   wire tx_last  = bit_q == BIT_LAST;
   wire prog_go  = stop_evt & wr_pend_q & ~internal_program_time_q;
   wire prog_end = internal_program_time_q & (prog_cnt_q == 32'h0000_0001);
   wire [ADDR_W-1:0] wr_next = {mem_addr_q[ADDR_W-1:PAGE_W], mem_addr_q[PAGE_W-1:0] + 4'h1};

   // Open drain: data held low, only enable moves
   assign bus.dev_sda_o    = 1'b0;
   assign bus.dev_sda_oe_n = sda_rel_q;

   // ==========================================================
   // Program cycle timer
   // Lockout length
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         internal_program_time_q <= 1'b0;
         prog_cnt_q              <= 32'h0000_0000;
      end else if (prog_go) begin
         internal_program_time_q <= 1'b1;
         prog_cnt_q              <= 32'(PROG_CYCLES);
      end else if (prog_end) begin
         internal_program_time_q <= 1'b0;
         prog_cnt_q              <= 32'h0000_0000;
      end else if (internal_program_time_q) begin
         prog_cnt_q <= prog_cnt_q - 32'h0000_0001;
      end
   end

   // ==========================================================
   // Byte framing and acknowledge
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_q     <= DS_IDLE;
         phase_q     <= PH_SLAVE;
         bit_q       <= 4'h0;
         rx_sh_q     <= 8'h00;
         tx_sh_q     <= 8'h00;
         rd_sel_q    <= 1'b0;
         m_ack_q     <= 1'b0;
         wr_pend_q   <= 1'b0;
         sda_rel_q   <= 1'b1;
         mem_addr_q  <= '0;
         mem_wdata_q <= 8'h00;
         mem_we_q    <= 1'b0;
      end else begin
         mem_we_q <= 1'b0;
         if (mem_we_q) begin
            mem_addr_q <= wr_next;
         end
         if (prog_go) begin
            wr_pend_q <= 1'b0;
         end
         if (internal_program_time_q) begin
            state_q   <= DS_IDLE;
            sda_rel_q <= 1'b1;
         end else if (start_evt) begin
            state_q   <= DS_RX;
            phase_q   <= PH_SLAVE;
            bit_q     <= 4'h0;
            sda_rel_q <= 1'b1;
         end else if (stop_evt) begin
            state_q   <= DS_IDLE;
            sda_rel_q <= 1'b1;
         end else begin
            case (state_q)
               DS_RX: begin
                  if (scl_rise) begin
                     rx_sh_q <= {rx_sh_q[6:0], sda_f};
                     bit_q   <= bit_q + 4'h1;
                  end else if (byte_in) begin
                     case (phase_q)
                        PH_SLAVE: begin
                           if (addr_hit) begin
                              state_q   <= DS_RX_ACK;
                              sda_rel_q <= 1'b0;
                              rd_sel_q  <= rx_sh_q[RW_POS];
                              phase_q   <= PH_WORD;
                           end else begin
                              state_q <= DS_WAIT;
                           end
                        end
                        PH_WORD: begin
                           mem_addr_q <= rx_sh_q;
                           phase_q    <= PH_DATA;
                           state_q    <= DS_RX_ACK;
                           sda_rel_q  <= 1'b0;
                        end
                        default: begin
                           mem_wdata_q <= rx_sh_q;
                           mem_we_q    <= 1'b1;
                           wr_pend_q   <= 1'b1;
                           state_q     <= DS_RX_ACK;
                           sda_rel_q   <= 1'b0;
                        end
                     endcase
                  end
               end
               DS_RX_ACK: begin
                  if (scl_fall) begin
                     bit_q <= 4'h0;
                     if (rd_sel_q) begin
                        state_q   <= DS_TX;
                        tx_sh_q   <= mem_rdata;
                        sda_rel_q <= mem_rdata[7];
                     end else begin
                        state_q   <= DS_RX;
                        sda_rel_q <= 1'b1;
                     end
                  end
               end
               DS_TX: begin
                  if (scl_fall) begin
                     if (tx_last) begin
                        state_q    <= DS_TX_ACK;
                        sda_rel_q  <= 1'b1;
                        mem_addr_q <= mem_addr_q + 8'h01;
                     end else begin
                        tx_sh_q   <= {tx_sh_q[6:0], 1'b0};
                        sda_rel_q <= tx_sh_q[6];
                        bit_q     <= bit_q + 4'h1;
                     end
                  end
               end
               DS_TX_ACK: begin
                  if (scl_rise) begin
                     m_ack_q <= ~sda_f;
                  end else if (scl_fall) begin
                     bit_q <= 4'h0;
                     if (m_ack_q) begin
                        state_q   <= DS_TX;
                        tx_sh_q   <= mem_rdata;
                        sda_rel_q <= mem_rdata[7];
                     end else begin
                        state_q <= DS_WAIT;
                     end
                  end
               end
               default: begin
                  // Idle and wait: only start or stop moves us
                  sda_rel_q <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule

// [rtl/sebs_mst.sv]
// Master end of the two-wire bus: makes SCL by division and runs start, stop, byte commands.
// Assumes a user that offers one command at a time under valid/ready.
module sebs_mst
   import sebs_pkg::*;
#(
   parameter int QTR_CYC = QTR_STD_CYC
) (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   // Bus side
   sebs_bus_if.mst                bus,
   // Command
   input  wire logic              cmd_valid,
   input  wire sebs_cmd_t         cmd_kind,
   input  wire logic [7:0]        cmd_wdata,
   input  wire logic              cmd_ack,
   output logic                   cmd_ready_q,
   // Answer
   output logic                   rsp_valid_q,
   output logic [7:0]             rsp_rdata_q,
   output logic                   rsp_acked_q
);

   localparam logic [15:0] QTR_END = 16'(QTR_CYC - 1);

   // ==========================================================
   // SDA sync and quarter-bit tick
   logic        sda_s1_q;
   logic        sda_s2_q;
   logic [15:0] qtr_q;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
      end else begin
         sda_s1_q <= bus.sda;
         sda_s2_q <= sda_s1_q;
      end
   end

   wire tick = qtr_q == QTR_END;

   // ==========================================================
   // Bit engine
   sebs_mst_state_t state_q;
   sebs_cmd_t       kind_q;
   logic [1:0]      ph_q;
   logic [3:0]      bit_q;
   logic [7:0]      sh_q;
   logic            ack_req_q;
   logic            scl_q;
   logic            sda_rel_q;

   wire is_rd    = kind_q == CMD_READ;
   wire ack_slot = bit_q == BIT_ACK;
   wire ph_end   = tick & (ph_q == PHASE_LAST);
   // Release for the receiver's ack, or ack a read byte
   wire drive_rel = is_rd ? (ack_slot ? ~ack_req_q : 1'b1) : (ack_slot ? 1'b1 : sh_q[7]);

   assign bus.scl          = scl_q;
   assign bus.mst_sda_o    = 1'b0;
   assign bus.mst_sda_oe_n = sda_rel_q;

   always_ff @(posedge ref_clk) begin
      if (sys_rst || state_q == MS_IDLE || tick) begin
         qtr_q <= 16'h0000;
      end else begin
         qtr_q <= qtr_q + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_q     <= MS_IDLE;
         kind_q      <= CMD_START;
         ph_q        <= 2'h0;
         bit_q       <= 4'h0;
         sh_q        <= 8'h00;
         ack_req_q   <= 1'b0;
         scl_q       <= 1'b1;
         sda_rel_q   <= 1'b1;
         cmd_ready_q <= 1'b1;
         rsp_valid_q <= 1'b0;
         rsp_rdata_q <= 8'h00;
         rsp_acked_q <= 1'b0;
      end else begin
         rsp_valid_q <= 1'b0;
         if (state_q == MS_IDLE) begin
            if (cmd_valid && cmd_ready_q) begin
               cmd_ready_q <= 1'b0;
               kind_q      <= cmd_kind;
               sh_q        <= cmd_wdata;
               ack_req_q   <= cmd_ack;
               ph_q        <= 2'h0;
               bit_q       <= 4'h0;
               case (cmd_kind)
                  CMD_START: state_q <= MS_COND;
                  CMD_STOP:  state_q <= MS_STOP;
                  default:   state_q <= MS_BYTE;
               endcase
            end
         end else if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (state_q)
               MS_COND: begin
                  // Start: SDA falls under high SCL
                  case (ph_q)
                     2'h0:    sda_rel_q <= 1'b1;
                     2'h1:    scl_q     <= 1'b1;
                     2'h2:    sda_rel_q <= 1'b0;
                     default: scl_q     <= 1'b0;
                  endcase
               end
               MS_STOP: begin
                  // Stop: SDA rises under high SCL
                  case (ph_q)
                     2'h0:    sda_rel_q <= 1'b0;
                     2'h1:    scl_q     <= 1'b1;
                     2'h2:    sda_rel_q <= 1'b1;
                     default: sda_rel_q <= 1'b1;
                  endcase
               end
               default: begin
                  case (ph_q)
                     2'h0:    sda_rel_q <= drive_rel;
                     2'h1:    scl_q     <= 1'b1;
                     2'h2: begin
                        if (ack_slot) begin
                           rsp_acked_q <= ~sda_s2_q;
                        end else if (is_rd) begin
                           rsp_rdata_q <= {rsp_rdata_q[6:0], sda_s2_q};
                        end
                     end
                     default: begin
                        scl_q <= 1'b0;
                        sh_q  <= {sh_q[6:0], 1'b0};
                        bit_q <= bit_q + 4'h1;
                     end
                  endcase
               end
            endcase
            if (ph_end && (state_q != MS_BYTE || ack_slot)) begin
               state_q     <= MS_IDLE;
               cmd_ready_q <= 1'b1;
               rsp_valid_q <= 1'b1;
            end
         end
      end
   end

endmodule

// [rtl/sebs_pkg.sv]
// Shared constants and types for the two-wire EEPROM bus slave and its master end.
// Assumes one 20 MHz system clock on both ends.
package sebs_pkg;

   // ==========================================================
   // Clock and timing
   localparam int CLK_HZ           = 20_000_000;
   localparam int CLK_PERIOD_NS    = 1_000_000_000 / CLK_HZ;
   localparam int CLK_PER_MS       = CLK_HZ / 1_000;
   localparam int PROG_TIME_STD_MS = 10;
   localparam int PROG_TIME_LV_MS  = 15;
   localparam int PROG_CYC_STD     = PROG_TIME_STD_MS * CLK_PER_MS;
   localparam int PROG_CYC_LV      = PROG_TIME_LV_MS * CLK_PER_MS;
   localparam int NOISE_STD_NS     = 100;
   localparam int NOISE_FAST_NS    = 50;
   localparam int NOISE_STD_CYC    = (NOISE_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NOISE_FAST_CYC   = (NOISE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCL_STD_HZ       = 100_000;
   localparam int SCL_FAST_HZ      = 400_000;
   localparam int QTR_STD_CYC      = (CLK_HZ + 4 * SCL_STD_HZ - 1) / (4 * SCL_STD_HZ);
   localparam int QTR_FAST_CYC     = (CLK_HZ + 4 * SCL_FAST_HZ - 1) / (4 * SCL_FAST_HZ);

   // ==========================================================
   // Framing
   localparam int         ADDR_W     = 8;
   localparam int         PAGE_W     = 4;
   localparam logic [3:0] DEV_TYPE   = 4'ha;
   localparam int         TYPE_LO    = 4;
   localparam int         CHIP_LO    = 1;
   localparam int         RW_POS     = 0;
   localparam logic [3:0] BIT_LAST   = 4'h7;
   localparam logic [3:0] BIT_ACK    = 4'h8;
   localparam logic [1:0] PHASE_LAST = 2'h3;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {PH_SLAVE = 2'h0, PH_WORD = 2'h1, PH_DATA = 2'h3} sebs_phase_t;

   typedef enum logic [2:0] {
      DS_IDLE   = 3'h0,
      DS_RX     = 3'h1,
      DS_RX_ACK = 3'h3,
      DS_TX     = 3'h2,
      DS_TX_ACK = 3'h6,
      DS_WAIT   = 3'h7
   } sebs_dev_state_t;

   typedef enum logic [1:0] {MS_IDLE = 2'h0, MS_COND = 2'h1, MS_BYTE = 2'h3, MS_STOP = 2'h2} sebs_mst_state_t;

   typedef enum logic [1:0] {CMD_START = 2'h0, CMD_STOP = 2'h1, CMD_WRITE = 2'h2, CMD_READ = 2'h3} sebs_cmd_t;

endpackage

// [tb/sebs_assertions.sv]
// Concurrent checks on the two-wire bus joining the master end and the slave end.
// Assumes the bench hands over the bus signals and the master's quarter period.
module sebs_assertions #(
   parameter int QTR_CYC = 13
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Bus lines
   input wire logic scl,
   input wire logic sda,
   input wire logic mst_sda_o,
   input wire logic mst_sda_oe_n,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe_n
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   // ==========================================================
   // Helper: cycles since the last SCL change, saturating
   logic [7:0] run_q;
   always_ff @(posedge ref_clk) begin
      if (sys_rst || $changed(scl))
         run_q <= 8'h00;
      else if (run_q != 8'hff)
         run_q <= run_q + 8'h01;
   end

   // ==========================================================
   // Assertions
   a_dev_open_drain:
      assert property (dev_sda_o == 1'b0) else $error("slave data output not low");
   a_mst_open_drain:
      assert property (mst_sda_o == 1'b0) else $error("master data output not low");
   a_dev_scl_low:
      assert property ($changed(dev_sda_oe_n) |-> !scl && !$past(scl))
         else $error("slave moved SDA while SCL high");
   a_start_dev_idle:
      assert property (scl && $fell(sda) |-> dev_sda_oe_n && $past(dev_sda_oe_n))
         else $error("slave held SDA at start");
   a_stop_dev_idle:
      assert property (scl && $rose(sda) |-> dev_sda_oe_n [*8]) else $error("slave drove SDA after stop");
   a_reset_bus_idle:
      assert property (disable iff (1'b0) sys_rst |=> scl && mst_sda_oe_n && dev_sda_oe_n)
         else $error("bus not idle in reset");
   a_scl_low_hold:
      assert property ($fell(scl) |-> !scl [*8]) else $error("SCL low phase too short");
   a_scl_quarter_min:
      assert property ($changed(scl) |-> run_q >= QTR_CYC) else $error("SCL phase below quarter period");

   // ==========================================================
   // Covers
   c_start: cover property (scl && $fell(sda));
   c_stop: cover property (scl && $rose(sda));
   c_dev_ack: cover property ($fell(dev_sda_oe_n));
endmodule

// [tb/serial_eeprom_bus_slave_bench.sv]
// Self-checking bench: master end and slave end joined by the bus interface.
// Assumes a byte store here that answers the slave end within the cycle.
module serial_eeprom_bus_slave_bench import sebs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;

   // Fast bus keeps the run short; program time shortened likewise
   localparam int         QTR   = QTR_FAST_CYC;
   localparam int         PROG  = 2000;
   localparam logic [2:0] STRAP = 3'h5;
   localparam logic [7:0] SLV_W = {DEV_TYPE, STRAP, 1'b0};

   logic       ref_clk;
   logic       sys_rst;
   logic [2:0] strap;
   logic       cmd_valid;
   sebs_cmd_t  cmd_kind;
   logic [7:0] cmd_wdata;
   logic       cmd_ack;
   logic       cmd_ready_q;
   logic       rsp_valid_q;
   logic [7:0] rsp_rdata_q;
   logic       rsp_acked_q;
   logic [7:0] mem_addr_q;
   logic [7:0] mem_wdata_q;
   logic       mem_we_q;
   logic [7:0] mem_rdata;
   logic       prog_q;
   logic [7:0] mem [256];
   int         busy_cycles = 0;
   int         cycles = 0;
   int         n_mismatch = 0;
   int         samples_checked = 0;

   // ==========================================================
   // Structure
   sebs_bus_if u_sebs_bus_if ();
   // One 2K device alone on this bus
   sebs_dev #(.FAST_MODE(1'b1), .PROG_CYCLES(PROG)) u_sebs_dev (
      .ref_clk, .sys_rst, .bus(u_sebs_bus_if),
      .chip_select_strap_bit0(strap[0]), .chip_select_strap_bit1(strap[1]), .chip_select_strap_bit2(strap[2]),
      .mem_addr_q, .mem_wdata_q, .mem_we_q, .mem_rdata, .internal_program_time_q(prog_q));
   sebs_mst #(.QTR_CYC(QTR)) u_sebs_mst (
      .ref_clk, .sys_rst, .bus(u_sebs_bus_if), .cmd_valid, .cmd_kind, .cmd_wdata, .cmd_ack,
      .cmd_ready_q, .rsp_valid_q, .rsp_rdata_q, .rsp_acked_q);
   sebs_assertions #(.QTR_CYC(QTR)) u_sebs_assertions (
      .ref_clk, .sys_rst, .scl(u_sebs_bus_if.scl), .sda(u_sebs_bus_if.sda),
      .mst_sda_o(u_sebs_bus_if.mst_sda_o), .mst_sda_oe_n(u_sebs_bus_if.mst_sda_oe_n),
      .dev_sda_o(u_sebs_bus_if.dev_sda_o), .dev_sda_oe_n(u_sebs_bus_if.dev_sda_oe_n));

   // ==========================================================
   // Clock, byte store, lockout length, hang guard
   always #25 ref_clk = ~ref_clk;
   assign mem_rdata = mem[mem_addr_q];
   always @(posedge ref_clk) begin
      if (mem_we_q === 1'b1)
         mem[mem_addr_q] <= mem_wdata_q;
      if (prog_q === 1'b1)
         busy_cycles <= busy_cycles + 1;
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   // ==========================================================
   // Tasks
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, seen);
         n_mismatch++;
      end
   endtask

   // Completion is bounded well above 36 quarters
   task automatic xfer(input sebs_cmd_t k, input logic [7:0] d, input logic a);
      int n;
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_kind <= k;
      cmd_wdata <= d;
      cmd_ack <= a;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (rsp_valid_q !== 1'b1 && n < 1000);
      if (n >= 1000)
         chk("completion", 8'h00, 8'h01);
      chk("ready", cmd_ready_q, 1'b1);
   endtask

   task automatic addr_try(input logic [7:0] a, input logic e);
      xfer(CMD_START, 8'h00, 1'b0);
      xfer(CMD_WRITE, a, 1'b0);
      chk("address ack", rsp_acked_q, e);
      xfer(CMD_STOP, 8'h00, 1'b0);
   endtask

   task automatic rread(input logic [7:0] a);
      xfer(CMD_START, 8'h00, 1'b0);
      xfer(CMD_WRITE, SLV_W, 1'b0);
      xfer(CMD_WRITE, a, 1'b0);
      xfer(CMD_START, 8'h00, 1'b0);
      xfer(CMD_WRITE, SLV_W | 8'h01, 1'b0);
      chk("read address ack", rsp_acked_q, 1'b1);
   endtask

   task automatic rd(input logic a, input logic [7:0] e);
      xfer(CMD_READ, 8'h00, a);
      chk("read byte", rsp_rdata_q, e);
   endtask

   task report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ==========================================================
   // Tests
   initial begin
      int w;
      ref_clk = 1'b0;
      sys_rst = 1'b1;
      strap = STRAP;
      cmd_valid = 1'b0;
      cmd_kind = CMD_START;
      cmd_wdata = 8'h00;
      cmd_ack = 1'b0;
      for (int i = 0; i < 256; i++)
         mem[i] = ~i[7:0];
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      // Every strap level, matched and mismatched
      for (int s = 0; s < 8; s++) begin
         @(posedge ref_clk);
         strap <= s[2:0];
         repeat (4) @(posedge ref_clk);
         addr_try({DEV_TYPE, s[2:0], 1'b0}, 1'b1);
         addr_try({DEV_TYPE, ~s[2:0], 1'b0}, 1'b0);
      end
      @(posedge ref_clk);
      strap <= STRAP;
      addr_try({4'hb, STRAP, 1'b0}, 1'b0);
      $display("test address done");
      // Three bytes from 3e wrap inside the page
      // Type, chip, then byte address
      xfer(CMD_START, 8'h00, 1'b0);
      xfer(CMD_WRITE, SLV_W, 1'b0);
      xfer(CMD_WRITE, 8'h3e, 1'b0);
      chk("byte address ack", rsp_acked_q, 1'b1);
      for (int i = 1; i < 4; i++) begin
         xfer(CMD_WRITE, 8'h11 * i[7:0], 1'b0);
         chk("data ack", rsp_acked_q, 1'b1);
      end
      xfer(CMD_STOP, 8'h00, 1'b0);
      repeat (10) @(posedge ref_clk);
      chk("lockout", prog_q, 1'b1);
      chk("byte 3f", mem[8'h3f], 8'h22);
      chk("byte 30", mem[8'h30], 8'h33);
      chk("byte 40", mem[8'h40], 8'hbf);
      addr_try(SLV_W, 1'b0);
      w = 0;
      while (prog_q !== 1'b0 && w < 3000) begin
         @(posedge ref_clk);
         w++;
      end
      #1;
      chk("lockout length", busy_cycles[7:0], PROG[7:0]);
      chk("lockout high", busy_cycles[15:8], PROG[15:8]);
      $display("test page write done");
      // Sequential read across page end, full increment
      rread(8'h3e);
      rd(1'b1, 8'h11);
      rd(1'b1, 8'h22);
      rd(1'b0, 8'hbf);
      xfer(CMD_STOP, 8'h00, 1'b0);
      // After a nack the slave stays off the line
      rread(8'h30);
      rd(1'b0, 8'h33);
      rd(1'b0, 8'hff);
      xfer(CMD_STOP, 8'h00, 1'b0);
      $display("test read done");
      report_and_stop();
   end
endmodule
